// ===== logic/sacu_exec_unit.sv
// execution-stage shifter, alignment check, pc operand and condition unit
`timescale 1ns/10ps

module sacu_exec_unit
    import sacu_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // instruction from decode
    input  wire logic        i_issue,
    input  wire logic [3:0]  i_cond,
    input  wire logic [2:0]  i_shift_op,
    input  wire logic [7:0]  i_shift_amt,
    input  wire logic [31:0] i_operand,
    input  wire logic        i_setflags,
    input  wire logic [3:0]  i_flag_mask,
    input  wire logic        i_arith,
    input  wire logic        i_n_in,
    input  wire logic        i_z_in,
    input  wire logic        i_c_in,
    input  wire logic        i_v_in,
    input  wire logic        i_mem_en,
    input  wire logic [2:0]  i_mem_kind,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_pc,
    input  wire logic        i_pc_branch,
    // results
    output logic             o_valid,
    output logic             o_exec,
    output logic             o_wr_en,
    output logic             o_fault,
    output logic [31:0]      o_result,
    output logic             o_carry,
    output logic [31:0]      o_pc_operand,
    output logic [3:0]       o_flags,
    // avalon-mm slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);

    // shifter: returns {carry, result}
    function automatic logic [32:0] sacu_shift(
        input logic [2:0]  op,
        input logic [31:0] v,
        input logic [7:0]  amt,
        input logic        cin
    );
        logic [4:0]  lo;
        logic [4:0]  idx;
        logic [63:0] dbl;
        logic [31:0] r;
        logic        c;
        lo  = amt[4:0];
        idx = lo - 5'h01;
        dbl = {v, v} >> lo;
        r   = v;
        c   = cin;
        unique case (op)
            SH_ARITH_RIGHT: begin
                if (amt == SH_AMT_NONE) begin
                    r = v; // [RULE1]
                end else if (amt >= SH_AMT_WORD) begin
                    r = {32{v[31]}}; // [RULE4]
                    c = v[31]; // [RULE4]
                end else begin
                    r = 32'($signed(v) >>> lo); // [RULE2]
                    c = v[idx]; // [RULE3]
                end
            end
            SH_LOGICAL_RIGHT: begin
                if (amt == SH_AMT_NONE) begin
                    r = v; // [RULE1]
                end else if (amt > SH_AMT_WORD) begin
                    r = READ_ZERO; // [RULE6]
                    c = 1'b0; // [RULE6]
                end else if (amt == SH_AMT_WORD) begin
                    r = READ_ZERO; // [RULE6]
                    c = v[31];
                end else begin
                    r = v >> lo; // [RULE5]
                    c = v[idx]; // [RULE6]
                end
            end
            SH_LOGICAL_LEFT: begin
                if (amt == SH_AMT_NONE) begin
                    r = v; // [RULE1] [RULE9]
                end else if (amt > SH_AMT_WORD) begin
                    r = READ_ZERO; // [RULE8]
                    c = 1'b0; // [RULE8]
                end else if (amt == SH_AMT_WORD) begin
                    r = READ_ZERO; // [RULE8]
                    c = v[0];
                end else begin
                    r = v << lo; // [RULE7]
                    c = v[~idx]; // [RULE8]
                end
            end
            SH_ROTATE_RIGHT: begin
                if (amt == SH_AMT_NONE) begin
                    r = v; // [RULE1]
                end else if (lo == 5'h00) begin
                    // 32, 64, ... all reduce to a full turn
                    r = v; // [RULE12] [RULE13]
                    c = v[31]; // [RULE12]
                end else begin
                    r = dbl[31:0]; // [RULE10] [RULE13]
                    c = v[idx]; // [RULE11]
                end
            end
            SH_ROTATE_CARRY: begin
                r = {cin, v[31:1]}; // [RULE14]
                c = v[0]; // [RULE15]
            end
            default: begin
                r = v;
                c = cin;
            end
        endcase
        return {c, r};
    endfunction

    // condition test against the flags word
    function automatic logic sacu_cond_pass(
        input logic [3:0] cc,
        input logic [3:0] f
    );
        logic n;
        logic z;
        logic c;
        logic v;
        logic p;
        n = f[FL_N];
        z = f[FL_Z];
        c = f[FL_C];
        v = f[FL_V];
        unique case (cc)
            CC_EQ:   p = z; // [RULE23]
            CC_NE:   p = !z;
            CC_CS:   p = c;
            CC_CC:   p = !c;
            CC_MI:   p = n;
            CC_PL:   p = !n;
            CC_VS:   p = v;
            CC_VC:   p = !v;
            CC_HI:   p = c && !z;
            CC_LS:   p = !c || z;
            CC_GE:   p = (n == v); // [RULE23]
            CC_LT:   p = (n != v);
            CC_GT:   p = !z && (n == v);
            CC_LE:   p = z || (n != v);
            default: p = 1'b1; // always
        endcase
        return p;
    endfunction

    logic [3:0]       flags;
    logic             trap_en;
    logic [31:0]      fault_addr;
    logic [CNT_W-1:0] exec_cnt;
    logic [CNT_W-1:0] skip_cnt;
    logic             bus_ack;

    logic [32:0] sh;
    logic        cond_ok;
    logic        do_exec;
    logic        misaligned;
    logic        unalign_ok;
    logic        fault;
    logic        shift_moves;
    logic [3:0]  hw_mask;
    logic [3:0]  hw_val;
    logic [3:0]  next_flags;
    logic [31:0] next_pc_operand;
    logic        bus_req;
    logic        bus_wr;

    assign sh      = sacu_shift(i_shift_op, i_operand, i_shift_amt, flags[FL_C]);
    assign cond_ok = sacu_cond_pass(i_cond, flags);
    assign do_exec = i_issue && cond_ok; // [RULE21]

    // alignment check
    always_comb begin
        unique case (i_mem_kind)
            MK_BYTE:                                misaligned = 1'b0; // [RULE17]
            MK_HALF_LOAD, MK_HALF_LDS, MK_HALF_STR,
            MK_HALF_CHK:                            misaligned = i_addr[0]; // [RULE17]
            default:                                misaligned = |i_addr[1:0]; // [RULE17]
        endcase
    end

    assign unalign_ok = (i_mem_kind == MK_WORD_LOAD) || (i_mem_kind == MK_WORD_STR)
                     || (i_mem_kind == MK_HALF_LOAD) || (i_mem_kind == MK_HALF_LDS)
                     || (i_mem_kind == MK_HALF_STR); // [RULE16]

    // a failed condition never faults
    assign fault = do_exec && i_mem_en && misaligned
                && (!unalign_ok || trap_en); // [RULE18] [RULE25] [RULE21]

    // for a non-arithmetic op, carry moves only for a nonzero shift or a rotate through carry
    assign shift_moves = (i_shift_amt != SH_AMT_NONE)
                      || (i_shift_op == SH_ROTATE_CARRY); // [RULE1] [RULE9]

    always_comb begin
        hw_mask = {4{do_exec && !fault && i_setflags}} & i_flag_mask; // [RULE22] [RULE21]
        if (!i_arith && !shift_moves) begin
            hw_mask[FL_C] = 1'b0; // [RULE1] [RULE9]
        end
        hw_val        = 4'h0;
        hw_val[FL_N]  = i_n_in;
        hw_val[FL_Z]  = i_z_in;
        hw_val[FL_C]  = i_arith ? i_c_in : sh[32]; // [RULE24]
        hw_val[FL_V]  = i_v_in;
    end

    // avalon handshake: one wait cycle, then accepted
    assign bus_req           = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = bus_req && !bus_ack;
    assign bus_wr            = i_avs_write && bus_ack && i_avs_byteenable[0];

    // hardware flag update wins over a software write in the same cycle
    always_comb begin
        next_flags = flags;
        if (bus_wr && i_avs_address == REG_FLAGS) begin
            next_flags = i_avs_writedata[3:0];
        end
        next_flags = (next_flags & ~hw_mask) | (hw_val & hw_mask); // [RULE22]
    end

    always_comb begin
        next_pc_operand = i_pc + PC_AHEAD; // [RULE19]
        if (!i_pc_branch) begin
            next_pc_operand = next_pc_operand & PC_WORD_CLR; // [RULE20]
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_valid      <= 1'b0;
            o_exec       <= 1'b0;
            o_wr_en      <= 1'b0;
            o_fault      <= 1'b0;
            o_result     <= READ_ZERO;
            o_carry      <= 1'b0;
            o_pc_operand <= READ_ZERO;
        end else begin
            o_valid      <= i_issue;
            o_exec       <= do_exec && !fault; // [RULE21]
            o_wr_en      <= do_exec && !fault; // [RULE21] [RULE18]
            o_fault      <= fault; // [RULE18]
            o_result     <= sh[31:0];
            o_carry      <= sh[32];
            o_pc_operand <= next_pc_operand;
        end
    end

    assign o_flags = flags;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fault_addr <= READ_ZERO;
        end else if (fault) begin
            fault_addr <= i_addr;
        end
    end

    // counters wrap; software reads them as a rough activity gauge
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            exec_cnt <= '0;
            skip_cnt <= '0;
        end else if (i_issue) begin
            if (do_exec) begin
                exec_cnt <= exec_cnt + 1'b1;
            end else begin
                skip_cnt <= skip_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trap_en <= 1'b0;
        end else if (bus_wr && i_avs_address == REG_CTRL) begin
            trap_en <= i_avs_writedata[CTRL_TRAP_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req && !bus_ack;
        end
    end

    // read data is loaded in the wait cycle so it stands at the accepting edge
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avs_readdata <= READ_ZERO;
        end else if (i_avs_read && !bus_ack) begin
            unique case (i_avs_address)
                REG_CTRL:       o_avs_readdata <= {31'h0, trap_en};
                REG_FLAGS:      o_avs_readdata <= {28'h0, flags};
                REG_FAULT_ADDR: o_avs_readdata <= fault_addr;
                REG_COUNTS:     o_avs_readdata <= 32'({skip_cnt, exec_cnt});
                default:        o_avs_readdata <= READ_ZERO;
            endcase
        end
    end

endmodule

// ===== pkg/sacu_pkg.sv
// constants and encodings for the shifter, alignment and condition unit
// Overview of operation
// RULE1 - shift amount zero passes operand unchanged and leaves carry alone
// RULE2 - arithmetic right shift moves upper bits down, fills top with sign bit
// RULE3 - flag-setting arithmetic right shift takes carry from operand bit n-1
// RULE4 - arithmetic right shift of 32 or more gives sign bits and sign carry
// RULE5 - logical right shift moves upper bits down and clears top n bits
// RULE6 - logical right carry is bit n-1; 32+ gives zero; 33+ zero carry
// RULE7 - left shift moves lower bits up, clears bottom bits, no overflow signal
// RULE8 - left shift carry is bit 32-n; 32+ gives zero; 33+ zero carry
// RULE9 - left shift by zero in a flag-setting operand leaves carry alone
// RULE10 - rotate right moves upper bits down and wraps low bits to the top
// RULE11 - flag-setting rotate right takes carry from operand bit n-1
// RULE12 - rotate by exactly 32 returns operand, carry from bit 31
// RULE13 - rotate amount above 32 behaves as that amount minus 32
// RULE14 - rotate through carry shifts right one, carry flag into bit 31
// RULE15 - flag-setting rotate through carry takes new carry from bit 0
// RULE16 - unaligned allowed only for word and halfword load/store group
// RULE17 - bytes always aligned; halfwords need halfword, wider need word alignment
// RULE18 - misaligned access outside permitted group raises misuse fault
// RULE19 - branches and compare-zero branches see pc operand address plus 4
// RULE20 - other pc-relative uses see address plus 4 with bit 1 cleared
// RULE21 - failed condition: no execute, no write, no flags, no exception
// RULE22 - an instruction updates only its own flags; others keep value
// RULE23 - condition codes decode against negative, zero, carry, overflow flags
// RULE24 - non-arithmetic shifting instructions take carry from last bit shifted out
// RULE25 - misalign trap bit set makes every unaligned access fault
package sacu_pkg;

    // shift operations
    localparam logic [2:0] SH_ARITH_RIGHT   = 3'h0;
    localparam logic [2:0] SH_LOGICAL_RIGHT = 3'h1;
    localparam logic [2:0] SH_LOGICAL_LEFT  = 3'h2;
    localparam logic [2:0] SH_ROTATE_RIGHT  = 3'h3;
    localparam logic [2:0] SH_ROTATE_CARRY  = 3'h4;

    localparam logic [7:0] SH_AMT_NONE = 8'h00;
    localparam logic [7:0] SH_AMT_WORD = 8'h20;

    // memory access kinds, unprivileged variants share a code
    localparam logic [2:0] MK_BYTE      = 3'h0;
    localparam logic [2:0] MK_HALF_LOAD = 3'h1;
    localparam logic [2:0] MK_HALF_LDS  = 3'h2;
    localparam logic [2:0] MK_HALF_STR  = 3'h3;
    localparam logic [2:0] MK_WORD_LOAD = 3'h4;
    localparam logic [2:0] MK_WORD_STR  = 3'h5;
    localparam logic [2:0] MK_HALF_CHK  = 3'h6;
    localparam logic [2:0] MK_WORD_CHK  = 3'h7;

    // condition codes
    localparam logic [3:0] CC_EQ = 4'h0;
    localparam logic [3:0] CC_NE = 4'h1;
    localparam logic [3:0] CC_CS = 4'h2;
    localparam logic [3:0] CC_CC = 4'h3;
    localparam logic [3:0] CC_MI = 4'h4;
    localparam logic [3:0] CC_PL = 4'h5;
    localparam logic [3:0] CC_VS = 4'h6;
    localparam logic [3:0] CC_VC = 4'h7;
    localparam logic [3:0] CC_HI = 4'h8;
    localparam logic [3:0] CC_LS = 4'h9;
    localparam logic [3:0] CC_GE = 4'hA;
    localparam logic [3:0] CC_LT = 4'hB;
    localparam logic [3:0] CC_GT = 4'hC;
    localparam logic [3:0] CC_LE = 4'hD;
    localparam logic [3:0] CC_AL = 4'hE;

    // flag positions within the flags word
    localparam int FL_N = 3;
    localparam int FL_Z = 2;
    localparam int FL_C = 1;
    localparam int FL_V = 0;

    // pc operand
    localparam logic [31:0] PC_AHEAD    = 32'h0000_0004;
    localparam logic [31:0] PC_WORD_CLR = 32'hFFFF_FFFD;

    // register map, byte addresses
    localparam logic [3:0] REG_CTRL       = 4'h0;
    localparam logic [3:0] REG_FLAGS      = 4'h4;
    localparam logic [3:0] REG_FAULT_ADDR = 4'h8;
    localparam logic [3:0] REG_COUNTS     = 4'hC;

    localparam int          CTRL_TRAP_BIT = 0;
    localparam logic [3:0]  FLAGS_RESET   = 4'h0;
    localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

endpackage

// ===== test/sacu_exec_asserts.sv
// port-level checks for the execution unit
`timescale 1ns/10ps

module sacu_exec_asserts
    import sacu_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_issue,
    input wire logic [2:0]  i_shift_op,
    input wire logic [7:0]  i_shift_amt,
    input wire logic [31:0] i_operand,
    input wire logic [3:0]  i_flag_mask,
    input wire logic        i_avs_write,
    input wire logic        i_mem_en,
    input wire logic [2:0]  i_mem_kind,
    input wire logic [31:0] i_pc,
    input wire logic        i_pc_branch,
    input wire logic        o_valid,
    input wire logic        o_exec,
    input wire logic        o_wr_en,
    input wire logic        o_fault,
    input wire logic [31:0] o_result,
    input wire logic        o_carry,
    input wire logic [31:0] o_pc_operand,
    input wire logic [3:0]  o_flags
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire logic big = i_shift_amt >= SH_AMT_WORD;
    wire logic op_is_ror = i_issue && i_shift_op == SH_ROTATE_RIGHT;

    a_zero_pass: assert property (
        i_issue && i_shift_amt == SH_AMT_NONE && i_shift_op != SH_ROTATE_CARRY
        |=> o_result == $past(i_operand)) else $error("zero shift altered operand");
    a_asr_wide: assert property (i_issue && i_shift_op == SH_ARITH_RIGHT && big
        |=> o_result == {32{$past(i_operand[31])}} && o_carry == $past(i_operand[31]))
        else $error("wide arithmetic shift wrong");
    a_lsr_wide: assert property (i_issue && i_shift_op == SH_LOGICAL_RIGHT && big
        |=> o_result == READ_ZERO) else $error("wide right shift not zero");
    a_lsl_wide: assert property (i_issue && i_shift_op == SH_LOGICAL_LEFT && big
        |=> o_result == READ_ZERO) else $error("wide left shift not zero");
    a_rrx_wrap: assert property (i_issue && i_shift_op == SH_ROTATE_CARRY
        |=> o_result == {$past(o_flags[FL_C]), $past(i_operand[31:1])}
        && o_carry == $past(i_operand[0])) else $error("carry rotate wrong");
    a_ror_word: assert property (op_is_ror && i_shift_amt == SH_AMT_WORD
        |=> o_result == $past(i_operand) && o_carry == $past(i_operand[31]))
        else $error("rotate by word wrong");
    a_pc_branch: assert property (i_issue && i_pc_branch
        |=> o_pc_operand == $past(i_pc) + PC_AHEAD) else $error("branch pc operand wrong");
    a_pc_word: assert property (i_issue && !i_pc_branch
        |=> o_pc_operand == (($past(i_pc) + PC_AHEAD) & PC_WORD_CLR))
        else $error("word pc operand wrong");
    a_byte_aligned: assert property (i_issue && i_mem_en && i_mem_kind == MK_BYTE
        |=> !o_fault) else $error("byte access faulted");
    a_fault_quiet: assert property (o_valid |-> o_wr_en == o_exec && !(o_fault && o_exec))
        else $error("write or fault inconsistent");
    a_mask_hold: assert property (i_issue && i_flag_mask == 4'h0 && !i_avs_write
        |=> $stable(o_flags)) else $error("flags changed without mask");

    c_fault: cover property (o_valid && o_fault);
    c_skip: cover property (o_valid && !o_exec && !o_fault);
    c_rrx: cover property (i_issue && i_shift_op == SH_ROTATE_CARRY);
endmodule

// ===== test/sacu_decode_model.sv
// decode stage model issuing one instruction at a time
`timescale 1ns/10ps

module sacu_decode_model
    import sacu_pkg::*;
(
    input  wire logic   i_clk,
    output logic        o_issue,
    output logic [3:0]  o_cond,
    output logic [2:0]  o_shift_op,
    output logic [7:0]  o_shift_amt,
    output logic [31:0] o_operand,
    output logic        o_setflags,
    output logic [3:0]  o_flag_mask,
    output logic [4:0]  o_alu,
    output logic        o_mem_en,
    output logic [2:0]  o_mem_kind,
    output logic [31:0] o_addr,
    output logic [31:0] o_pc,
    output logic        o_pc_branch
);
    initial begin
        {o_issue, o_cond, o_shift_op, o_shift_amt, o_operand, o_setflags} = '0;
        {o_flag_mask, o_alu, o_mem_en, o_mem_kind, o_addr, o_pc, o_pc_branch} = '0;
    end

    // o_alu holds arith select then nzcv from the alu
    task automatic iss(input logic [3:0] cc, input logic [2:0] op, input logic [7:0] amt,
            input logic [31:0] v, input logic [3:0] m, input logic [4:0] ax = 5'h00,
            input logic mem = 1'b0, input logic [2:0] kind = MK_BYTE,
            input logic [31:0] adr = 32'h0, input logic [31:0] pc = 32'h0,
            input logic br = 1'b0);
        @(posedge i_clk);
        o_issue <= 1'b1;
        o_cond <= cc;
        o_shift_op <= op;
        o_shift_amt <= amt;
        o_operand <= v;
        o_setflags <= |m;
        o_flag_mask <= m;
        o_alu <= ax;
        o_mem_en <= mem;
        o_mem_kind <= kind;
        o_addr <= adr;
        o_pc <= pc;
        o_pc_branch <= br;
        @(posedge i_clk);
        o_issue <= 1'b0;
        // stale values must not pass for live ones
        o_operand <= ~v;
        o_addr <= ~adr;
        #1;
    endtask
endmodule

// ===== test/test_sacu_exec_unit.sv
// self-checking bench for the execution unit
`timescale 1ns/10ps

module test_sacu_exec_unit;
    import sacu_pkg::*;
    localparam logic [31:0] OPA = 32'h8000_0011;
    localparam logic [43:0] SHT [18] = '{
        {SH_LOGICAL_LEFT, 8'h00, OPA, 1'b0}, {SH_LOGICAL_LEFT, 8'h01, 32'h0000_0022, 1'b1},
        {SH_LOGICAL_LEFT, 8'h00, OPA, 1'b1}, {SH_ARITH_RIGHT, 8'h04, 32'hF800_0001, 1'b0},
        {SH_ARITH_RIGHT, 8'h20, 32'hFFFF_FFFF, 1'b1}, {SH_ARITH_RIGHT, 8'h28, 32'hFFFF_FFFF, 1'b1},
        {SH_LOGICAL_RIGHT, 8'h05, 32'h0400_0000, 1'b1}, {SH_LOGICAL_RIGHT, 8'h20, 32'h0, 1'b1},
        {SH_LOGICAL_RIGHT, 8'h21, 32'h0, 1'b0}, {SH_LOGICAL_LEFT, 8'h20, 32'h0, 1'b1},
        {SH_LOGICAL_LEFT, 8'h21, 32'h0, 1'b0}, {SH_ROTATE_CARRY, 8'h00, 32'h4000_0008, 1'b1},
        {SH_ROTATE_CARRY, 8'h00, 32'hC000_0008, 1'b1}, {SH_ROTATE_RIGHT, 8'h05, 32'h8C00_0000, 1'b1},
        {SH_ROTATE_RIGHT, 8'h20, OPA, 1'b1}, {SH_ROTATE_RIGHT, 8'h25, 32'h8C00_0000, 1'b1},
        {SH_ARITH_RIGHT, 8'h04, 32'hF800_0001, 1'b0}, {SH_ROTATE_RIGHT, 8'h00, OPA, 1'b0}};
    logic        i_clk, i_rstn, i_avs_read, i_avs_write;
    logic [3:0]  i_avs_address, i_avs_byteenable;
    logic [31:0] i_avs_writedata, rd;
    wire logic   issue, sf, mem_en, br, o_valid, o_exec, o_wr_en, o_fault, o_carry;
    wire logic   o_avs_waitrequest;
    wire logic [2:0]  op, kind;
    wire logic [3:0]  cond, mask, o_flags;
    wire logic [4:0]  alu;
    wire logic [7:0]  amt;
    wire logic [31:0] opnd, addr, pc, o_result, o_pc_operand, o_avs_readdata;
    int failures = 0;
    int cmp_count = 0;

    sacu_decode_model u_sacu_decode_model (.i_clk(i_clk), .o_issue(issue), .o_cond(cond),
        .o_shift_op(op), .o_shift_amt(amt), .o_operand(opnd), .o_setflags(sf),
        .o_flag_mask(mask), .o_alu(alu), .o_mem_en(mem_en), .o_mem_kind(kind),
        .o_addr(addr), .o_pc(pc), .o_pc_branch(br));
    sacu_exec_unit u_sacu_exec_unit (.i_clk(i_clk), .i_rstn(i_rstn), .i_issue(issue),
        .i_cond(cond), .i_shift_op(op), .i_shift_amt(amt), .i_operand(opnd),
        .i_setflags(sf), .i_flag_mask(mask), .i_arith(alu[4]), .i_n_in(alu[3]),
        .i_z_in(alu[2]), .i_c_in(alu[1]), .i_v_in(alu[0]), .i_mem_en(mem_en),
        .i_mem_kind(kind), .i_addr(addr), .i_pc(pc), .i_pc_branch(br), .o_valid(o_valid),
        .o_exec(o_exec), .o_wr_en(o_wr_en), .o_fault(o_fault), .o_result(o_result),
        .o_carry(o_carry), .o_pc_operand(o_pc_operand), .o_flags(o_flags),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // waitrequest is read mid-cycle so the edge's own update cannot race the sample
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] be, output logic [31:0] q);
        logic w;
        int k;
        @(posedge i_clk);
        i_avs_read <= !wr;
        i_avs_write <= wr;
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        for (k = 0; k < 20; k++) begin
            @(negedge i_clk);
            w = o_avs_waitrequest;
            q = o_avs_readdata;
            @(posedge i_clk);
            if (w === 1'b0) break;
        end
        if (k == 20) begin
            failures++;
            results();
        end
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        i_avs_writedata <= ~d;
    endtask

    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic b;
        case (c[3:1])
            3'h0: b = f[FL_Z];
            3'h1: b = f[FL_C];
            3'h2: b = f[FL_N];
            3'h3: b = f[FL_V];
            3'h4: b = f[FL_C] & !f[FL_Z];
            3'h5: b = f[FL_N] == f[FL_V];
            3'h6: b = !f[FL_Z] & (f[FL_N] == f[FL_V]);
            default: return 1'b1;
        endcase
        return b ^ c[0];
    endfunction

    task automatic t_shifts;
        logic [2:0] o;
        logic [7:0] n;
        logic [31:0] r;
        logic c;
        bus(1'b0, REG_FLAGS, 32'h0, 4'hF, rd);
        check("flags reset", rd, 32'h0);
        for (int i = 0; i < 18; i++) begin
            {o, n, r, c} = SHT[i];
            u_sacu_decode_model.iss(CC_AL, o, n, OPA, 4'h2);
            check("valid", {31'h0, o_valid}, 32'h1);
            check("result", o_result, r);
            if (n != 8'h00 || o == SH_ROTATE_CARRY)
                check("carry", {31'h0, o_carry}, {31'h0, c});
            check("flag c", {31'h0, o_flags[FL_C]}, {31'h0, c});
        end
    endtask

    task automatic t_cond;
        logic [3:0] fv [5] = '{4'h0, 4'h6, 4'h9, 4'hC, 4'h3};
        logic ok;
        for (int j = 0; j < 5; j++)
            for (int cc = 0; cc < 16; cc++) begin
                bus(1'b1, REG_FLAGS, {28'h0, fv[j]}, 4'hF, rd);
                u_sacu_decode_model.iss(cc[3:0], SH_LOGICAL_LEFT, 8'h01,
                    fv[j][FL_C] ? 32'h0 : 32'h8000_0000, 4'h2);
                ok = cond_ok(cc[3:0], fv[j]);
                check("exec", {31'h0, o_exec}, {31'h0, ok});
                check("flags", {28'h0, o_flags}, {28'h0, ok ? fv[j] ^ 4'h2 : fv[j]});
            end
    endtask

    task automatic t_mask;
        bus(1'b1, REG_FLAGS, 32'h0, 4'hF, rd);
        u_sacu_decode_model.iss(CC_AL, SH_LOGICAL_LEFT, 8'h00, 32'h0, 4'h9, 5'h1F);
        check("masked set", {28'h0, o_flags}, 32'h9);
        u_sacu_decode_model.iss(CC_AL, SH_LOGICAL_LEFT, 8'h00, 32'h0, 4'h2, 5'h12);
        check("arith carry", {28'h0, o_flags}, 32'hB);
    endtask

    task automatic t_align;
        logic mis, f;
        for (int t = 0; t < 2; t++) begin
            bus(1'b1, REG_CTRL, t, 4'hF, rd);
            for (int k = 0; k < 8; k++)
                for (int a = 1; a < 4; a++) begin
                    u_sacu_decode_model.iss(CC_AL, SH_LOGICAL_LEFT, 8'h00, 32'h0, 4'h0,
                        5'h00, 1'b1, k[2:0], 32'h100 + a);
                    mis = (k inside {1, 2, 3, 6}) ? a[0] : (k != 0);
                    f = mis && (t == 1 || !(k inside {1, 2, 3, 4, 5}));
                    check("fault", {31'h0, o_fault}, {31'h0, f});
                    check("exec", {31'h0, o_exec}, {31'h0, !f});
                end
        end
        bus(1'b0, REG_FAULT_ADDR, 32'h0, 4'hF, rd);
        check("fault addr", rd, 32'h103);
        bus(1'b1, REG_CTRL, 32'h0, 4'h0, rd);
        bus(1'b0, REG_CTRL, 32'h0, 4'hF, rd);
        check("ctrl kept", rd, 32'h1);
        bus(1'b0, 4'h2, 32'h0, 4'hF, rd);
        check("unmapped", rd, READ_ZERO);
        bus(1'b1, REG_FLAGS, 32'h0, 4'hF, rd);
        u_sacu_decode_model.iss(CC_EQ, SH_LOGICAL_LEFT, 8'h00, 32'h0, 4'h0, 5'h00, 1'b1,
            MK_WORD_CHK, 32'h101);
        check("skip no fault", {31'h0, o_fault}, 32'h0);
    endtask

    task automatic t_pc;
        u_sacu_decode_model.iss(CC_AL, SH_LOGICAL_LEFT, 8'h00, 32'h0, 4'h0, 5'h00, 1'b0,
            MK_BYTE, 32'h0, 32'h1002, 1'b1);
        check("pc branch", o_pc_operand, 32'h1006);
        u_sacu_decode_model.iss(CC_AL, SH_LOGICAL_LEFT, 8'h00, 32'h0, 4'h0, 5'h00, 1'b0,
            MK_BYTE, 32'h0, 32'h1002, 1'b0);
        check("pc word", o_pc_operand, 32'h1004);
    endtask

    initial begin
        i_rstn = 1'b0;
        {i_avs_read, i_avs_write, i_avs_address, i_avs_byteenable, i_avs_writedata} = '0;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_shifts;
        t_cond;
        t_mask;
        t_align;
        t_pc;
        results();
    end
endmodule

bind sacu_exec_unit sacu_exec_asserts u_sacu_exec_asserts (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_issue(i_issue), .i_shift_op(i_shift_op), .i_shift_amt(i_shift_amt),
    .i_operand(i_operand), .i_flag_mask(i_flag_mask), .i_avs_write(i_avs_write),
    .i_mem_en(i_mem_en), .i_mem_kind(i_mem_kind), .i_pc(i_pc), .i_pc_branch(i_pc_branch),
    .o_valid(o_valid), .o_exec(o_exec), .o_wr_en(o_wr_en), .o_fault(o_fault),
    .o_result(o_result), .o_carry(o_carry), .o_pc_operand(o_pc_operand), .o_flags(o_flags));
